// ===== src/asrc_pkg.sv
// shared constants for the array store relocation and bounds checker
package asrc_pkg;
    // default geometry
    localparam int EDGE_LOG2_DEF   = 6;        // array_edge_length = 2**6 = 64
    localparam int EDGE_LOG2_MIN   = 5;        // smallest legal edge is 32
    localparam int CODE_AW_DEF     = 17;       // 128K instruction slots
    localparam int CODE_AW_MIN     = 17;       // code space never below 128K instructions
    localparam int PLANE_AW_DEF    = 15;       // 32K planes, 32768 bits per element
    localparam int PLANE_AW_MIN    = 15;       // planes never below 32K
    localparam int INSTR_BYTES     = 4;        // one instruction occupies four bytes
    localparam int WORD_BITS       = 32;       // word width of the array store
    localparam int WORD_LOG2       = 5;        // log2 of WORD_BITS
    // plane map relative to the data base
    localparam int USER_WORK_LAST  = 119;      // last free workspace plane
    localparam int RSVD_FIRST      = 120;      // first run-time system plane
    localparam int RSVD_LAST       = 127;      // last run-time system plane
    localparam int LITERAL_FIRST   = 128;      // literals and read-only data start here
    // reset values
    localparam logic RST_FLAG      = 1'b0;     // flags and strobes clear at reset
endpackage

// ===== src/asrc_bounds.sv
// relocation adder and base/limit window compare
`timescale 1ns/1ps
`default_nettype none

module asrc_bounds #(
    parameter int W = 17                  // address width
) (
    input  wire logic [W-1:0] base,       // base register, hidden from user code
    input  wire logic [W-1:0] limit,      // limit register, highest legal address
    input  wire logic [W-1:0] offset,     // user-relative address
    output logic      [W-1:0] phys,       // relocated address
    output logic              in_range    // relocated address lies within base..limit
);
    ////////////////////////////////////////////////////////////////////////////
    // one extra bit catches wrap, which would otherwise look like a low address
    logic [W:0] sum;                      // full-width relocation sum
    logic       wrapped;                  // sum overflowed the address space
    logic       above;                    // past the limit
    logic       below;                    // under the base

    assign sum      = {1'b0, base} + {1'b0, offset};
    assign phys     = sum[W-1:0];
    assign wrapped  = sum[W];
    assign above    = phys > limit;
    assign below    = phys < base;
    assign in_range = !wrapped && !above && !below;
endmodule

`default_nettype wire

// ===== src/asrc_check.sv
// code and array store relocation, bounds check and word/row/plane addressing
`timescale 1ns/1ps
`default_nettype none

// Contract
// - instruction addresses relocate from hidden code base
// - error when above code limit or below base
// - code space holds at least 128K instructions
// - each element owns at least 32768 bits
// - element i,j owns bit i,j per plane
// - 32-bit words, edge/32 words per row
// - word 0 is a row's most significant bits
// - sequential words roll into next row, plane
// - planes count from hidden data base
// - error when relocated plane leaves base..limit
// - literals and read-only data from plane 128
// - square array, power-of-two edge
// - rows, columns 0..edge-1, row 0 north
// - array store holds at least 32K planes
// - one address broadcast to all elements
module asrc_check #(
    parameter int EDGE_LOG2 = asrc_pkg::EDGE_LOG2_DEF,  // log2 of array_edge_length
    parameter int CODE_AW   = asrc_pkg::CODE_AW_DEF,    // instruction address width
    parameter int PLANE_AW  = asrc_pkg::PLANE_AW_DEF,   // plane address width
    localparam int EL       = EDGE_LOG2,                // row index width
    localparam int WW       = (EDGE_LOG2 > asrc_pkg::WORD_LOG2) ? EDGE_LOG2 - asrc_pkg::WORD_LOG2 : 1,
    localparam int WCOUNT   = 2 ** (EDGE_LOG2 - asrc_pkg::WORD_LOG2)  // words per row
) (
    input  wire logic                clk,             // 40 MHz system clock
    input  wire logic                arst_n,          // asynchronous reset, active low
    input  wire logic                sup_code_load,   // supervisor loads code base and limit
    input  wire logic [CODE_AW-1:0]  sup_code_base,   // new code base
    input  wire logic [CODE_AW-1:0]  sup_code_limit,  // new code limit
    input  wire logic                sup_data_load,   // supervisor loads store base and limit
    input  wire logic [PLANE_AW-1:0] sup_data_base,   // new store base plane
    input  wire logic [PLANE_AW-1:0] sup_data_limit,  // new store limit plane
    input  wire logic                sup_err_clear,   // supervisor clears the error
    input  wire logic                code_req,        // instruction fetch request
    input  wire logic [CODE_AW-1:0]  code_offset,     // program-relative instruction address
    input  wire logic                data_req,        // array store word request
    input  wire logic                data_seq,        // take the word after the last granted one
    input  wire logic                data_write,      // request is a write
    input  wire logic [PLANE_AW-1:0] data_plane,      // user-relative plane
    input  wire logic [EL-1:0]       data_row,        // row, 0 is north
    input  wire logic [WW-1:0]       data_word,       // word within row
    output logic                     code_grant,      // fetch allowed, one-cycle pulse
    output logic [CODE_AW-1:0]       code_addr,       // physical instruction address
    output logic                     data_grant,      // store access allowed, one-cycle pulse
    output logic                     data_write_en,   // broadcast write strobe
    output logic [PLANE_AW-1:0]      mem_plane,       // physical plane, broadcast
    output logic [EL-1:0]            mem_row,         // row, broadcast
    output logic [WW-1:0]            mem_word,        // word within row, broadcast
    output logic [EL-1:0]            mem_bit_msb,     // bit position of the word's msb
    output logic                     data_literal,    // relative plane is in literal area
    output logic                     data_reserved,   // relative plane is run-time reserved
    output logic                     run_error,       // sticky run-time error
    output logic                     err_code_side,   // error came from a fetch
    output logic                     err_data_side    // error came from a store access
);
    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    // square array, edge a power of two
    // at least 32K planes per element store
    // 32K planes give 32768 bits each
    initial begin
        if (EDGE_LOG2 < asrc_pkg::EDGE_LOG2_MIN || EDGE_LOG2 > 16)
            $error("edge exponent out of range");
        if (CODE_AW < asrc_pkg::CODE_AW_MIN || CODE_AW > 31)
            $error("code address width too small");
        if (PLANE_AW < asrc_pkg::PLANE_AW_MIN || PLANE_AW > 31)
            $error("plane address width too small");
    end

    // word 0 starts at bit 0, the row's msb
    function automatic logic [EL-1:0] word_msb(input logic [WW-1:0] w);
        word_msb = EL'(32'(w) << asrc_pkg::WORD_LOG2);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // hidden base and limit registers: only supervisor ports reach them
    logic [CODE_AW-1:0]  code_base_q;     // code base
    logic [CODE_AW-1:0]  code_limit_q;    // code limit
    logic [PLANE_AW-1:0] data_base_q;     // store base plane
    logic [PLANE_AW-1:0] data_limit_q;    // store limit plane
    logic [PLANE_AW-1:0] last_plane;      // last granted relative plane
    logic [EL-1:0]       last_row;        // last granted row
    logic [WW-1:0]       last_word;       // last granted word

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            code_base_q  <= '0;
            code_limit_q <= '0;
            data_base_q  <= '0;
            data_limit_q <= '0;
        end else begin
            if (sup_code_load) begin
                code_base_q  <= sup_code_base;
                code_limit_q <= sup_code_limit;
            end
            if (sup_data_load) begin
                data_base_q  <= sup_data_base;
                data_limit_q <= sup_data_limit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequential word stepping over row and plane boundaries
    logic                word_last;       // last word of the row
    logic                row_last;        // last (south) row of the plane
    logic [WW-1:0]       seq_word;        // next word
    logic [EL-1:0]       seq_row;         // next row
    logic [PLANE_AW-1:0] seq_plane;       // next relative plane

    // word after last of a row/plane
    assign word_last = (last_word == WW'(WCOUNT - 1));
    assign row_last  = &last_row;
    assign seq_word  = word_last ? '0 : WW'(last_word + 1'b1);
    assign seq_row   = word_last ? EL'(last_row + 1'b1) : last_row;
    assign seq_plane = (word_last && row_last) ? PLANE_AW'(last_plane + 1'b1) : last_plane;

    logic [PLANE_AW-1:0] rel_plane;       // selected relative plane
    logic [EL-1:0]       rel_row;         // selected row
    logic [WW-1:0]       rel_word;        // selected word

    // row index straight through, 0 north
    assign rel_plane = data_seq ? seq_plane : data_plane;
    assign rel_row   = data_seq ? seq_row   : data_row;
    assign rel_word  = data_seq ? seq_word  : data_word;

    ////////////////////////////////////////////////////////////////////////////
    // relocation and bounds for both spaces
    logic [CODE_AW-1:0]  code_phys;       // relocated instruction address
    logic                code_ok;         // fetch within window
    logic [PLANE_AW-1:0] data_phys;       // relocated plane
    logic                data_ok;         // plane within window

    // window check on the relocated fetch
    asrc_bounds #(.W(CODE_AW)) u_code (
        .base     (code_base_q),
        .limit    (code_limit_q),
        .offset   (code_offset),
        .phys     (code_phys),
        .in_range (code_ok)
    );

    // plane zero is the store base
    // window check on the relocated plane
    asrc_bounds #(.W(PLANE_AW)) u_data (
        .base     (data_base_q),
        .limit    (data_limit_q),
        .offset   (rel_plane),
        .phys     (data_phys),
        .in_range (data_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request qualification
    logic code_take;                      // fetch taken this cycle
    logic data_take;                      // store access taken this cycle
    logic code_fault;                     // fetch out of window
    logic data_fault;                     // store access out of window
    logic next_error;                     // error flag next value

    // nothing is taken while the error stands
    assign code_take  = code_req && !run_error;
    assign data_take  = data_req && !run_error;
    assign code_fault = code_take && !code_ok;
    assign data_fault = data_take && !data_ok;
    // a fault in the clearing cycle still sets the flag
    assign next_error = code_fault || data_fault || (run_error && !sup_err_clear);

    ////////////////////////////////////////////////////////////////////////////
    // error flag and cause
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_error     <= asrc_pkg::RST_FLAG;
            err_code_side <= asrc_pkg::RST_FLAG;
            err_data_side <= asrc_pkg::RST_FLAG;
        end else begin
            run_error     <= next_error;
            err_code_side <= code_fault || (err_code_side && !sup_err_clear);
            err_data_side <= data_fault || (err_data_side && !sup_err_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch answer
    // grant only after a passing check
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            code_grant <= asrc_pkg::RST_FLAG;
            code_addr  <= '0;
        end else begin
            code_grant <= code_take && code_ok;
            if (code_take && code_ok)
                code_addr <= code_phys;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // store answer, one address for the whole element array
    // single broadcast address set
    // write strobe gated by the check
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_grant    <= asrc_pkg::RST_FLAG;
            data_write_en <= asrc_pkg::RST_FLAG;
            mem_plane     <= '0;
            mem_row       <= '0;
            mem_word      <= '0;
            mem_bit_msb   <= '0;
            data_literal  <= asrc_pkg::RST_FLAG;
            data_reserved <= asrc_pkg::RST_FLAG;
            last_plane    <= '0;
            last_row      <= '0;
            last_word     <= '0;
        end else begin
            data_grant    <= data_take && data_ok;
            data_write_en <= data_take && data_ok && data_write;
            if (data_take && data_ok) begin
                mem_plane     <= data_phys;
                mem_row       <= rel_row;
                mem_word      <= rel_word;
                mem_bit_msb   <= word_msb(rel_word);
                data_literal  <= (32'(rel_plane) >= asrc_pkg::LITERAL_FIRST);
                // reserved area marker for the supervisor
                data_reserved <= (32'(rel_plane) >= asrc_pkg::RSVD_FIRST)
                              && (32'(rel_plane) <= asrc_pkg::RSVD_LAST);
                last_plane    <= rel_plane;
                last_row      <= rel_row;
                last_word     <= rel_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_code_grant_window: assert property (@(posedge clk) disable iff (!arst_n)
        code_grant |-> (code_addr >= code_base_q) && (code_addr <= code_limit_q))
        else $error("fetch granted outside code window");

    a_code_reloc_sum: assert property (@(posedge clk) disable iff (!arst_n)
        code_req && !run_error && code_ok ##1 code_grant
        |-> code_addr == CODE_AW'($past(code_base_q) + $past(code_offset)))
        else $error("fetch address not base plus offset");

    a_code_fault_err: assert property (@(posedge clk) disable iff (!arst_n)
        code_req && !run_error && !code_ok |=> run_error && err_code_side && !code_grant)
        else $error("bad fetch did not raise error");

    a_data_fault_nowr: assert property (@(posedge clk) disable iff (!arst_n)
        data_req && !run_error && !data_ok |=> !data_write_en && !data_grant && run_error)
        else $error("bad store access reached the store");

    a_data_plane_window: assert property (@(posedge clk) disable iff (!arst_n)
        data_grant |-> (mem_plane >= data_base_q) && (mem_plane <= data_limit_q))
        else $error("store access granted outside window");

    a_error_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        run_error && !sup_err_clear |=> run_error [*1] ##0 !code_grant && !data_grant)
        else $error("error flag dropped or request passed");

    a_word_msb_pos: assert property (@(posedge clk) disable iff (!arst_n)
        data_grant |-> 32'(mem_bit_msb) == 32'(mem_word) * asrc_pkg::WORD_BITS)
        else $error("word bit position wrong");

    a_seq_row_roll: assert property (@(posedge clk) disable iff (!arst_n)
        data_req && data_seq && !run_error && data_ok && word_last && !row_last
        |=> data_grant && mem_word == '0 && mem_row == EL'($past(last_row) + 1'b1))
        else $error("sequential step did not enter next row");

    a_seq_plane_roll: assert property (@(posedge clk) disable iff (!arst_n)
        data_req && data_seq && !run_error && data_ok && word_last && row_last
        |=> mem_row == '0 && last_plane == PLANE_AW'($past(last_plane) + 1'b1))
        else $error("sequential step did not enter next plane");

    a_literal_mark: assert property (@(posedge clk) disable iff (!arst_n)
        data_grant |-> data_literal == (32'(last_plane) >= asrc_pkg::LITERAL_FIRST))
        else $error("literal area marker wrong");
endmodule

`default_nettype wire

// ===== bench/asrc_seq_model.sv
// master sequencer model issuing fetch and array store requests
`timescale 1ns/1ps
`default_nettype none

module asrc_seq_model #(
    parameter int CAW = 17,                 // instruction address width
    parameter int PAW = 15,                 // plane address width
    parameter int EL  = 6,                  // row index width
    parameter int WW  = 1                   // word index width
) (
    input  wire logic           clk,        // system clock
    output logic                code_req,   // fetch request
    output logic [CAW-1:0]      code_offset,// relative instruction address
    output logic                data_req,   // store request
    output logic                data_seq,   // next word after last granted
    output logic                data_write, // write request
    output logic [PAW-1:0]      data_plane, // relative plane
    output logic [EL-1:0]       data_row,   // row, 0 is north
    output logic [WW-1:0]       data_word   // word in row
);
    ////////////////////////////////////////////////////////////////
    // idle at time zero, nothing requested
    initial begin
        code_req    = 1'b0;
        code_offset = '0;
        data_req    = 1'b0;
        data_seq    = 1'b0;
        data_write  = 1'b0;
        data_plane  = '0;
        data_row    = '0;
        data_word   = '0;
    end

    ////////////////////////////////////////////////////////////////
    // one fetch, called at a falling edge, returns a falling edge later
    task automatic fetch(input logic [CAW-1:0] off);
        code_req    = 1'b1;
        code_offset = off;
        @(negedge clk);
    endtask

    // one store request; back to back when called again at once
    task automatic access(input logic wr, input logic sq, input logic [PAW-1:0] pl,
                          input logic [EL-1:0] rw, input logic [WW-1:0] wd);
        data_req   = 1'b1;
        // sequential step left to the block
        data_seq   = sq;
        // never write run-time or literal planes named directly; sequential steps pass the write through
        data_write = wr && (sq || pl < asrc_pkg::RSVD_FIRST);
        data_plane = pl;
        data_row   = rw;
        data_word  = wd;
        @(negedge clk);
    endtask

    // drop both requests; a stale offset would hide nothing, so flip it
    task automatic idle;
        code_req    = 1'b0;
        data_req    = 1'b0;
        code_offset = ~code_offset;
        data_plane  = ~data_plane;
    endtask
endmodule

`default_nettype wire

// ===== bench/array_store_relocation_check_test.sv
// self-checking bench for the relocation and bounds checker
`timescale 1ns/1ps
`default_nettype none

module array_store_relocation_check_test;
    localparam int EL = 6;                  // log2 edge, 64 elements
    localparam int CAW = 17;                // code address width
    localparam int PAW = 15;                // plane address width
    localparam int WW = 1;                  // word index width
    logic clk, arst_n, sup_code_load, sup_data_load, sup_err_clear;
    logic [CAW-1:0] sup_code_base, sup_code_limit, code_offset, code_addr;
    logic [PAW-1:0] sup_data_base, sup_data_limit, data_plane, mem_plane;
    logic code_req, data_req, data_seq, data_write, code_grant, data_grant, data_write_en;
    logic [EL-1:0] data_row, mem_row, mem_bit_msb;
    logic [WW-1:0] data_word, mem_word;
    logic data_literal, data_reserved, run_error, err_code_side, err_data_side;
    int n_errors, samples_checked;
    logic [PAW-1:0] fl_pl [4] = '{15'h0077, 15'h0078, 15'h007F, 15'h0080}; // planes around the map edges

    asrc_check #(.EDGE_LOG2(EL), .CODE_AW(CAW), .PLANE_AW(PAW)) u_asrc_check (.clk(clk), .arst_n(arst_n),
        .sup_code_load(sup_code_load), .sup_code_base(sup_code_base), .sup_code_limit(sup_code_limit),
        .sup_data_load(sup_data_load), .sup_data_base(sup_data_base), .sup_data_limit(sup_data_limit),
        .sup_err_clear(sup_err_clear), .code_req(code_req), .code_offset(code_offset), .data_req(data_req),
        .data_seq(data_seq), .data_write(data_write), .data_plane(data_plane), .data_row(data_row),
        .data_word(data_word), .code_grant(code_grant), .code_addr(code_addr), .data_grant(data_grant),
        .data_write_en(data_write_en), .mem_plane(mem_plane), .mem_row(mem_row), .mem_word(mem_word),
        .mem_bit_msb(mem_bit_msb), .data_literal(data_literal), .data_reserved(data_reserved),
        .run_error(run_error), .err_code_side(err_code_side), .err_data_side(err_data_side));

    asrc_seq_model #(.CAW(CAW), .PAW(PAW), .EL(EL), .WW(WW)) u_asrc_seq_model (.clk(clk), .code_req(code_req),
        .code_offset(code_offset), .data_req(data_req), .data_seq(data_seq), .data_write(data_write),
        .data_plane(data_plane), .data_row(data_row), .data_word(data_word));

    ////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    // compare, count, report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // supervisor window loads and error clear, one cycle each
    task automatic load_win(input logic [CAW-1:0] cb, cl, input logic [PAW-1:0] db, dl);
        {sup_code_base, sup_code_limit, sup_data_base, sup_data_limit} = {cb, cl, db, dl};
        {sup_code_load, sup_data_load} = 2'b11;
        @(negedge clk);
        {sup_code_load, sup_data_load} = 2'b00;
    endtask

    task automatic clear_err;
        sup_err_clear = 1'b1;
        @(negedge clk);
        sup_err_clear = 1'b0;
        check("run_error cleared", run_error, 0);
    endtask

    ////////////////////////////////////////////////////////////////
    // fetch relocation, limit edge, wrap and blocking
    task automatic sc_code;
        load_win(17'h00064, 17'h000C8, 15'h000A, 15'h0064);
        u_asrc_seq_model.fetch(17'h00005);
        check("code_addr", code_addr, 32'h69);
        check("code_grant", code_grant, 1);
        u_asrc_seq_model.fetch(17'h00064);
        check("code_addr at limit", code_addr, 32'hC8);
        u_asrc_seq_model.fetch(17'h00065);
        check("code_grant above limit", code_grant, 0);
        check("err_code_side", err_code_side, 1);
        u_asrc_seq_model.fetch(17'h00005);
        check("fetch while error", code_grant, 0);
        check("code_addr held", code_addr, 32'hC8);
        u_asrc_seq_model.idle();
        clear_err();
        u_asrc_seq_model.fetch(17'h1FFFF);
        check("wrapped fetch", {code_grant, run_error}, 1);
        u_asrc_seq_model.idle();
        clear_err();
    endtask

    // store relocation, word layout and sequential roll-over
    task automatic sc_data;
        u_asrc_seq_model.access(1, 0, 15'h0003, 6'h02, 1'h1);
        check("write grant", {data_grant, data_write_en}, 3);
        check("mem_plane", mem_plane, 32'hD);
        check("mem_word", {mem_row, mem_word}, {2'h2, 1'h1});
        check("mem_bit_msb", mem_bit_msb, asrc_pkg::WORD_BITS);
        u_asrc_seq_model.access(0, 1, 15'h0000, 6'h00, 1'h0);
        check("seq row step", {mem_plane, mem_row, mem_word}, {15'hD, 6'h3, 1'h0});
        check("seq read", {data_grant, data_write_en}, 2);
        u_asrc_seq_model.access(0, 0, 15'h0005, 6'h3F, 1'h1);
        check("south row", mem_row, 32'h3F);
        u_asrc_seq_model.access(0, 1, 15'h0000, 6'h00, 1'h0);
        check("seq plane step", {mem_plane, mem_row, mem_word}, {15'h10, 6'h0, 1'h0});
        check("msb word 0", mem_bit_msb, 0);
        u_asrc_seq_model.idle();
    endtask

    // out of window write is stopped before any strobe
    task automatic sc_fault;
        u_asrc_seq_model.access(1, 0, 15'h005A, 6'h00, 1'h0);
        check("write at limit", data_write_en, 1);
        u_asrc_seq_model.access(1, 0, 15'h005B, 6'h00, 1'h0);
        check("write past limit", {data_grant, data_write_en}, 0);
        check("err_data_side", {run_error, err_data_side}, 3);
        check("plane unchanged", mem_plane, 32'h64);
        u_asrc_seq_model.access(0, 0, 15'h0001, 6'h00, 1'h0);
        check("store while error", data_grant, 0);
        u_asrc_seq_model.idle();
        clear_err();
        check("cause cleared", err_data_side, 0);
    endtask

    // reserved and literal plane flags
    task automatic sc_flags;
        load_win(17'h00000, 17'h1FFFF, 15'h000A, 15'h012C);
        for (int i = 0; i < 4; i++) begin
            u_asrc_seq_model.access(0, 0, fl_pl[i], 6'h00, 1'h0);
            check("data_reserved", data_reserved, fl_pl[i] inside {[120:127]});
            check("data_literal", data_literal, fl_pl[i] >= asrc_pkg::LITERAL_FIRST);
        end
        u_asrc_seq_model.idle();
    endtask

    // full code space and plane count reach
    task automatic sc_capacity;
        load_win(17'h00000, 17'h1FFFF, 15'h0000, 15'h7FFF);
        u_asrc_seq_model.fetch(17'h1FFFF);
        u_asrc_seq_model.access(0, 0, 15'h7FFF, 6'h3F, 1'h1);
        check("top instruction", {code_grant, code_addr}, {1'b1, 17'h1FFFF});
        check("top plane", {data_grant, mem_plane}, {1'b1, 15'h7FFF});
        check("error free", run_error, 0);
        u_asrc_seq_model.idle();
    endtask

    // one window reloaded alone, the other keeps its registers
    task automatic sc_partial;
        {sup_code_base, sup_code_limit, sup_data_base, sup_data_limit} = {17'h10, 17'h20, 15'h7000, 15'h7000};
        sup_code_load = 1'b1;
        @(negedge clk);
        sup_code_load = 1'b0;
        u_asrc_seq_model.access(0, 0, 15'h7FFF, 6'h00, 1'h0);
        check("data window kept", {data_grant, mem_plane}, {1'b1, 15'h7FFF});
        u_asrc_seq_model.fetch(17'h00011);
        check("code window reloaded", {code_grant, run_error}, 1);
        u_asrc_seq_model.idle();
        clear_err();
        {sup_code_base, sup_code_limit} = '0;
        sup_data_load = 1'b1;
        @(negedge clk);
        sup_data_load = 1'b0;
        u_asrc_seq_model.fetch(17'h00005);
        check("code window kept", {code_grant, code_addr}, {1'b1, 17'h15});
        u_asrc_seq_model.access(0, 0, 15'h0000, 6'h00, 1'h0);
        check("data window reloaded", {data_grant, mem_plane}, {1'b1, 15'h7000});
        u_asrc_seq_model.access(0, 0, 15'h1000, 6'h00, 1'h0);
        check("wrapped plane", {data_grant, err_data_side}, 1);
        u_asrc_seq_model.idle();
        clear_err();
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_errors = 0;
        samples_checked = 0;
        arst_n = 1'b0;
        {sup_code_load, sup_data_load, sup_err_clear} = 3'b000;
        {sup_code_base, sup_code_limit, sup_data_base, sup_data_limit} = '0;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        check("reset outputs", {code_grant, data_grant, run_error, mem_plane}, 0);
        sc_code();
        sc_data();
        sc_fault();
        sc_flags();
        sc_capacity();
        sc_partial();
        final_report();
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule

`default_nettype wire
